/* File: timer01_pkg.sv */
// Register map, field positions and divider constants for the timer block.
package timer01_pkg;
   // Register addresses on the special-function-register port.
   localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
   localparam logic [7:0] ADDR_MODE = 8'h89;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h8a;
   localparam logic [7:0] ADDR_CLK_SEL = 8'h8e;
   // Reset values.
   localparam logic [7:0] RST_RUN_FLAGS = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_COUNT_LOW = 8'h00;
   localparam logic [7:0] RST_CLK_SEL = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // Run and flag register fields.
   localparam int OVF1_BIT = 7;
   localparam int RUN1_BIT = 6;
   localparam int OVF0_BIT = 5;
   localparam int RUN0_BIT = 4;
   localparam int XIRQ1_BIT = 3;
   localparam int XTYP1_BIT = 2;
   localparam int XIRQ0_BIT = 1;
   localparam int XTYP0_BIT = 0;
   // Mode register fields.
   localparam int GATED1_BIT = 7;
   localparam int CT1_BIT = 6;
   localparam int M1_LSB = 4;
   localparam int GATED0_BIT = 3;
   localparam int CT0_BIT = 2;
   localparam int M0_LSB = 0;
   // Clock select register fields; timer 3 pair sits two above timer 2.
   localparam int LO2_SYS_BIT = 4;
   localparam int HI2_SYS_BIT = 5;
   localparam int SYS1_BIT = 3;
   localparam int SYS0_BIT = 2;
   localparam int SCA_LSB = 0;
   // Divider ratios and the terminal counts derived from them.
   localparam int DIV_SYS12 = 12;
   localparam int DIV_SYS4 = 4;
   localparam int DIV_SYS48 = 48;
   localparam int DIV_EXT8 = 8;
   localparam logic [3:0] DIV12_LAST = 4'(DIV_SYS12 - 1);
   localparam logic [1:0] DIV4_LAST = 2'(DIV_SYS4 - 1);
   localparam logic [1:0] DIV48_LAST = 2'(DIV_SYS48 / DIV_SYS12 - 1);
   localparam logic [2:0] EXT8_LAST = 3'(DIV_EXT8 - 1);
   // Timer operating modes in field order.
   typedef enum logic [1:0] {
      MODE_13BIT, MODE_16BIT, MODE_8BIT_RELOAD, MODE_SPLIT
   } timer_mode_t;
   // Prescaler selections in field order.
   typedef enum logic [1:0] {
      PRESCALE_DIV12, PRESCALE_DIV4, PRESCALE_DIV48, PRESCALE_EXT8
   } prescale_t;
endpackage : timer01_pkg

/* File: tick_if.sv */
// Interface carrying prescaler selection and clock ticks to the control.
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   timer01_pkg::prescale_t prescale;
   logic presc_tick;
   logic div12_tick;
   logic ext8_tick;
   modport src (input prescale, output presc_tick, div12_tick, ext8_tick);
   modport sink (output prescale, input presc_tick, div12_tick, ext8_tick);
endinterface : tick_if
`default_nettype wire

/* File: pin_sync.sv */
// Two-flop pin synchroniser with edge detection on the synchronised level.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Raw pins and conditioned views.
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
   } sync_state_t;
   sync_state_t state_reg, state_next;

   // The meta stage feeds only the sync stage; edges compare later stages.
   always_comb begin
      state_next.meta = pin;
      state_next.sync = state_reg.meta;
      state_next.prev = state_reg.sync;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) state_reg <= '0;
      else state_reg <= state_next;
   end

   // Edges are one-cycle pulses.
   assign level = state_reg.sync;
   assign rise = state_reg.sync & ~state_reg.prev;
   assign fall = state_reg.prev & ~state_reg.sync;
endmodule : pin_sync
`default_nettype wire

/* File: timer_prescaler.sv */
// Shared prescaler: system divide by 12, 4 and 48, external divide by 8.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // External oscillator pin.
   input wire logic ext_clk,
   // Ticks to the control logic.
   tick_if.src ticks
);
   typedef struct packed {
      logic [3:0] c12;
      logic [1:0] c48;
      logic [2:0] c8;
   } presc_state_t;
   presc_state_t state_reg, state_next;
   logic ext_rise;
   logic wrap12;
   logic tick4;
   logic tick48;

   // The external clock is brought into the system domain first.
   pin_sync #(.WIDTH(1)) ext_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin(ext_clk),
      .level(),
      .rise(ext_rise),
      .fall()
   );

   assign wrap12 = state_reg.c12 == timer01_pkg::DIV12_LAST;
   assign tick4 = state_reg.c12[1:0] == timer01_pkg::DIV4_LAST;
   assign tick48 = wrap12 && state_reg.c48 == timer01_pkg::DIV48_LAST;

   // Divide by 4 shares the divide-by-12 counter since 4 divides 12.
   always_comb begin
      state_next = state_reg;
      state_next.c12 = wrap12 ? 4'h0 : state_reg.c12 + 4'h1;
      if (wrap12) state_next.c48 = state_reg.c48 + 2'h1;
      if (ext_rise) state_next.c8 = state_reg.c8 + 3'h1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) state_reg <= '0;
      else state_reg <= state_next;
   end

   // Selected prescaled tick.
   assign ticks.div12_tick = wrap12;
   assign ticks.ext8_tick = ext_rise && state_reg.c8 == timer01_pkg::EXT8_LAST;
   always_comb begin
      unique case (ticks.prescale)
         timer01_pkg::PRESCALE_DIV12: ticks.presc_tick = wrap12;
         timer01_pkg::PRESCALE_DIV4: ticks.presc_tick = tick4;
         timer01_pkg::PRESCALE_DIV48: ticks.presc_tick = tick48;
         timer01_pkg::PRESCALE_EXT8: ticks.presc_tick = ticks.ext8_tick;
      endcase
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_div12;
      wrap12 |-> ##12 wrap12;
   endproperty
   a_div12: assert property (p_div12) else $error("div12 period wrong");
   property p_div48;
      tick48 |-> ##48 tick48;
   endproperty
   a_div48: assert property (p_div48) else $error("div48 period wrong");
endmodule : timer_prescaler
`default_nettype wire

/* File: timer01_ctrl.sv */
// Control, mode and clock selection for timers 0 and 1, with timer 0 low byte.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Timer 1 overflow sets flag; vector clears.
// - Timer 0 overflow sets flag; vector clears.
// - Timer 1 runs on run bit, gated input.
// - Timer 0 runs on run bit, gated input.
// - Run bits disable at zero, enable at one.
// - Irq 1 flag edge or level; level follows.
// - Irq 0 flag edge or level; level follows.
// - Type bit zero level, one edge.
// - Timer 1 counts clock or pin falls.
// - Timer 0 counts clock or pin falls.
// - Timer 1 modes: 13, 16, reload, inactive.
// - Timer 0 modes: 13, 16, reload, split.
// - Timer 1 clock select: system or prescaled.
// - Timer 0 clock select: system or prescaled.
// - Prescale divides by 12, 4, 48, ext 8.
// - External divided clock is synchronised first.
// - Timer 3 high select only in split.
// - Timer 3 low select: system or external.
// - Timer 2 high select only in split.
// - Timer 2 low select: system or external.
// - Timer 0 low byte is CPU readable, writable.
// - 13-bit wrap from all ones sets flag.
// - Reload mode reloads low from high byte.
// - Split high byte uses timer 1 run, flag.
module timer01_ctrl (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Special function register port.
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Interrupt vector acknowledges from the core.
   input wire logic vec_timer0,
   input wire logic vec_timer1,
   input wire logic vec_ext_irq0,
   input wire logic vec_ext_irq1,
   // Pins.
   input wire logic timer0_count_pin,
   input wire logic timer1_count_pin,
   input wire logic ext_irq0_input,
   input wire logic ext_irq1_input,
   input wire logic ext_clk,
   // Polarity bits from the external interrupt configuration register.
   input wire logic ext_irq0_polarity,
   input wire logic ext_irq1_polarity,
   // Timer 0 high byte held outside.
   input wire logic [7:0] timer0_count_high,
   output logic timer0_high_inc,
   // Timer 1 count held outside.
   output logic timer1_tick,
   input wire logic timer1_overflow,
   // Timers 2 and 3 configuration and clock enables.
   input wire logic timer2_split,
   input wire logic timer3_split,
   input wire logic timer2_external_select,
   input wire logic timer3_external_select,
   output logic timer2_low_tick,
   output logic timer2_high_tick,
   output logic timer3_low_tick,
   output logic timer3_high_tick,
   // Flags to the interrupt controller.
   output logic timer0_overflow_flag,
   output logic timer1_overflow_flag,
   output logic ext_irq0_flag,
   output logic ext_irq1_flag
);
   typedef struct packed {
      logic [7:0] run_flags;
      logic [7:0] mode;
      logic [7:0] count_low;
      logic [7:0] clk_sel;
      logic [7:0] rdata;
   } ctrl_state_t;
   ctrl_state_t state_reg, state_next;

   tick_if ticks ();
   logic [3:0] pin_lvl;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   logic wr_flags, wr_mode, wr_low, wr_clk;
   logic run0, run1, gated0, gated1, ct0, ct1, sys0, sys1;
   timer01_pkg::timer_mode_t m0, m1;
   logic act0, act1, edge0, edge1;
   logic t0_src, t0_run, t0_tick, t0_carry, ovf0;
   logic th_tick, th_ovf, ovf1_set;
   logic t1_src, t1_run;
   logic tl_full, th_full;
   logic [1:0] ext_sel, split, lo_tick, hi_tick;

   // Pins 0..3: count pin 0, count pin 1, irq 0, irq 1.
   pin_sync #(.WIDTH(4)) pins (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin({ext_irq1_input, ext_irq0_input, timer1_count_pin,
            timer0_count_pin}),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   timer_prescaler presc (
      .ref_clk(ref_clk),
      .rst(rst),
      .ext_clk(ext_clk),
      .ticks(ticks.src)
   );
   assign ticks.prescale = timer01_pkg::prescale_t'(
      state_reg.clk_sel[timer01_pkg::SCA_LSB +: 2]);

   // Register write strobes.
   assign wr_flags = sfr_wr && sfr_addr == timer01_pkg::ADDR_RUN_FLAGS;
   assign wr_mode = sfr_wr && sfr_addr == timer01_pkg::ADDR_MODE;
   assign wr_low = sfr_wr && sfr_addr == timer01_pkg::ADDR_COUNT_LOW;
   assign wr_clk = sfr_wr && sfr_addr == timer01_pkg::ADDR_CLK_SEL;

   // Field views of the stored registers.
   assign run0 = state_reg.run_flags[timer01_pkg::RUN0_BIT];
   assign run1 = state_reg.run_flags[timer01_pkg::RUN1_BIT];
   assign gated0 = state_reg.mode[timer01_pkg::GATED0_BIT];
   assign gated1 = state_reg.mode[timer01_pkg::GATED1_BIT];
   assign ct0 = state_reg.mode[timer01_pkg::CT0_BIT];
   assign ct1 = state_reg.mode[timer01_pkg::CT1_BIT];
   assign sys0 = state_reg.clk_sel[timer01_pkg::SYS0_BIT];
   assign sys1 = state_reg.clk_sel[timer01_pkg::SYS1_BIT];
   assign m0 = timer01_pkg::timer_mode_t'(
      state_reg.mode[timer01_pkg::M0_LSB +: 2]);
   assign m1 = timer01_pkg::timer_mode_t'(
      state_reg.mode[timer01_pkg::M1_LSB +: 2]);

   // Interrupt inputs, active at the configured polarity.
   assign act0 = pin_lvl[2] ~^ ext_irq0_polarity;
   assign act1 = pin_lvl[3] ~^ ext_irq1_polarity;
   assign edge0 = ext_irq0_polarity ? pin_rise[2] : pin_fall[2];
   assign edge1 = ext_irq1_polarity ? pin_rise[3] : pin_fall[3];

   // Timer 0 source and run control.
   assign t0_src = ct0 ? pin_fall[0] : (sys0 | ticks.presc_tick);
   assign t0_run = run0 & (~gated0 | act0);
   assign t0_tick = t0_run & t0_src;

   // Carry out of the low byte, five bits wide in 13-bit mode.
   assign tl_full = &state_reg.count_low;
   assign th_full = &timer0_count_high;
   assign t0_carry = (m0 == timer01_pkg::MODE_13BIT) ?
      &state_reg.count_low[4:0] : tl_full;
   assign ovf0 = t0_tick & t0_carry &
      (m0 == timer01_pkg::MODE_8BIT_RELOAD ||
       m0 == timer01_pkg::MODE_SPLIT || th_full);

   // In split mode the high byte is a plain timer run by timer 1's run bit.
   assign th_tick = run1 & (sys0 | ticks.presc_tick);
   assign th_ovf = m0 == timer01_pkg::MODE_SPLIT && th_tick && th_full;
   assign timer0_high_inc = (m0 == timer01_pkg::MODE_SPLIT) ? th_tick :
      (t0_tick & t0_carry & (m0 != timer01_pkg::MODE_8BIT_RELOAD));

   // Timer 1 loses its pin and its flag while timer 0 is split.
   assign t1_src = (ct1 && m0 != timer01_pkg::MODE_SPLIT) ? pin_fall[1] :
      (sys1 | ticks.presc_tick);
   assign t1_run = m1 != timer01_pkg::MODE_SPLIT &&
      (m0 == timer01_pkg::MODE_SPLIT ||
       (run1 && (!gated1 || act1)));
   assign timer1_tick = t1_run & t1_src;
   assign ovf1_set = (m0 == timer01_pkg::MODE_SPLIT) ? th_ovf :
      timer1_overflow;

   // Timers 2 and 3 byte clocks; a select of one picks the system clock.
   assign ext_sel = {timer3_external_select, timer2_external_select};
   assign split = {timer3_split, timer2_split};
   generate
      for (genvar i = 0; i < 2; i++) begin : g_t23
         logic xclk;
         assign xclk = ext_sel[i] ? ticks.ext8_tick : ticks.div12_tick;
         assign lo_tick[i] =
            state_reg.clk_sel[timer01_pkg::LO2_SYS_BIT + 2 * i] | xclk;
         assign hi_tick[i] = split[i] ?
            (state_reg.clk_sel[timer01_pkg::HI2_SYS_BIT + 2 * i] | xclk) :
            lo_tick[i];
      end
   endgenerate
   assign timer2_low_tick = lo_tick[0];
   assign timer2_high_tick = hi_tick[0];
   assign timer3_low_tick = lo_tick[1];
   assign timer3_high_tick = hi_tick[1];

   // Next state: writes first, then hardware clears, then hardware sets.
   // Sets are ORed in last so an event never loses to a clear.
   always_comb begin
      state_next = state_reg;
      if (wr_flags) state_next.run_flags = sfr_wdata;
      if (wr_mode) state_next.mode = sfr_wdata;
      if (wr_clk) state_next.clk_sel = sfr_wdata;
      if (!wr_flags) begin
         if (vec_timer1)
            state_next.run_flags[timer01_pkg::OVF1_BIT] = 1'b0;
         if (vec_timer0)
            state_next.run_flags[timer01_pkg::OVF0_BIT] = 1'b0;
         if (vec_ext_irq1)
            state_next.run_flags[timer01_pkg::XIRQ1_BIT] = 1'b0;
         if (vec_ext_irq0)
            state_next.run_flags[timer01_pkg::XIRQ0_BIT] = 1'b0;
      end
      if (ovf1_set)
         state_next.run_flags[timer01_pkg::OVF1_BIT] = 1'b1;
      if (ovf0)
         state_next.run_flags[timer01_pkg::OVF0_BIT] = 1'b1;
      // Level type makes the flag a copy of the input; edge type latches.
      if (!state_next.run_flags[timer01_pkg::XTYP1_BIT])
         state_next.run_flags[timer01_pkg::XIRQ1_BIT] = act1;
      else if (edge1)
         state_next.run_flags[timer01_pkg::XIRQ1_BIT] = 1'b1;
      if (!state_next.run_flags[timer01_pkg::XTYP0_BIT])
         state_next.run_flags[timer01_pkg::XIRQ0_BIT] = act0;
      else if (edge0)
         state_next.run_flags[timer01_pkg::XIRQ0_BIT] = 1'b1;
      // A software load of the low byte takes priority over counting.
      if (wr_low) begin
         state_next.count_low = sfr_wdata;
      end else if (t0_tick) begin
         unique case (m0)
            timer01_pkg::MODE_13BIT: state_next.count_low[4:0] =
               state_reg.count_low[4:0] + 5'h01;
            timer01_pkg::MODE_16BIT: state_next.count_low =
               state_reg.count_low + 8'h01;
            timer01_pkg::MODE_8BIT_RELOAD: state_next.count_low = tl_full ?
               timer0_count_high : state_reg.count_low + 8'h01;
            timer01_pkg::MODE_SPLIT: state_next.count_low =
               state_reg.count_low + 8'h01;
         endcase
      end
      // Read data is captured on the read strobe and held until the next.
      if (sfr_rd) begin
         case (sfr_addr)
            timer01_pkg::ADDR_RUN_FLAGS:
               state_next.rdata = state_reg.run_flags;
            timer01_pkg::ADDR_MODE: state_next.rdata = state_reg.mode;
            timer01_pkg::ADDR_COUNT_LOW:
               state_next.rdata = state_reg.count_low;
            timer01_pkg::ADDR_CLK_SEL: state_next.rdata = state_reg.clk_sel;
            default: state_next.rdata = timer01_pkg::READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg.run_flags <= timer01_pkg::RST_RUN_FLAGS;
         state_reg.mode <= timer01_pkg::RST_MODE;
         state_reg.count_low <= timer01_pkg::RST_COUNT_LOW;
         state_reg.clk_sel <= timer01_pkg::RST_CLK_SEL;
         state_reg.rdata <= timer01_pkg::READ_UNMAPPED;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the read-data and flag registers.
   assign sfr_rdata = state_reg.rdata;
   assign timer1_overflow_flag = state_reg.run_flags[timer01_pkg::OVF1_BIT];
   assign timer0_overflow_flag = state_reg.run_flags[timer01_pkg::OVF0_BIT];
   assign ext_irq1_flag = state_reg.run_flags[timer01_pkg::XIRQ1_BIT];
   assign ext_irq0_flag = state_reg.run_flags[timer01_pkg::XIRQ0_BIT];

   // Checks on flag timing, gating and counting.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_reload_wrap;
      m0 == timer01_pkg::MODE_8BIT_RELOAD && t0_tick && tl_full && !wr_low;
   endsequence
   sequence s_wrap13;
      m0 == timer01_pkg::MODE_13BIT && t0_tick && t0_carry && th_full &&
      !wr_low;
   endsequence
   property p_ovf0_set;
      ovf0 |=> timer0_overflow_flag;
   endproperty
   a_ovf0_set: assert property (p_ovf0_set) else $error("ovf0 not set");
   property p_ovf0_vec;
      vec_timer0 && !ovf0 && !wr_flags |=> !timer0_overflow_flag;
   endproperty
   a_ovf0_vec: assert property (p_ovf0_vec) else $error("ovf0 kept");
   property p_ovf1_set;
      ovf1_set |=> timer1_overflow_flag;
   endproperty
   a_ovf1_set: assert property (p_ovf1_set) else $error("ovf1 not set");
   property p_gated0;
      (!run0 || (gated0 && !act0)) && !wr_low
      |=> $stable(state_reg.count_low);
   endproperty
   a_gated0: assert property (p_gated0) else $error("timer 0 ran gated");
   property p_level0;
      !state_reg.run_flags[timer01_pkg::XTYP0_BIT] && !wr_flags
      |=> ext_irq0_flag == $past(act0);
   endproperty
   a_level0: assert property (p_level0) else $error("irq0 level");
   property p_edge1;
      state_reg.run_flags[timer01_pkg::XTYP1_BIT] && !wr_flags && edge1
      |=> ext_irq1_flag;
   endproperty
   a_edge1: assert property (p_edge1) else $error("irq1 edge lost");
   property p_reload;
      s_reload_wrap |=> state_reg.count_low == $past(timer0_count_high)
      && timer0_overflow_flag;
   endproperty
   a_reload: assert property (p_reload) else $error("no reload");
   property p_wrap13;
      s_wrap13 |-> timer0_high_inc ##1
      (state_reg.count_low[4:0] == 5'h00 && timer0_overflow_flag);
   endproperty
   a_wrap13: assert property (p_wrap13) else $error("13-bit wrap");
   property p_t1_off;
      m1 == timer01_pkg::MODE_SPLIT |-> !timer1_tick;
   endproperty
   a_t1_off: assert property (p_t1_off) else $error("timer 1 ran off");
   property p_split_th;
      th_ovf && !wr_flags |=> timer1_overflow_flag;
   endproperty
   a_split_th: assert property (p_split_th) else $error("high ovf");
   property p_pin_count;
      ct0 && t0_run && pin_fall[0] && m0 == timer01_pkg::MODE_16BIT &&
      !wr_low |=> state_reg.count_low == $past(state_reg.count_low) + 8'h01;
   endproperty
   a_pin_count: assert property (p_pin_count) else $error("pin count");
endmodule : timer01_ctrl
`default_nettype wire

/* File: cpu_sfr_model.sv */
// Core-side model that drives the special-function-register port.
`timescale 1ns/1ps
`default_nettype none
module cpu_sfr_model (
   // Clock.
   input wire logic ref_clk,
   // Register port toward the timer block.
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic sfr_rd,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata
);
   // Quiet bus at time zero.
   initial begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
   end
   // One write; released lines show inverted values so stale ones never match.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
      sfr_addr <= ~a;
      sfr_wdata <= ~d;
   endtask : write_reg
   // One read; data is registered on the sampling edge, taken once settled.
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      sfr_addr <= ~a;
      #1 d = sfr_rdata;
   endtask : read_reg
endmodule : cpu_sfr_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the timer control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Stimulus and observed signals.
   logic ref_clk, rst, sfr_wr, sfr_rd, ext_clk, t1_ovf;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, t0_high, rd;
   logic [1:0] vec_t, vec_x, cnt_pin, irq_in, irq_pol, inc;
   logic [3:0] aux_in, ticks, flags, fl;
   int err_count, checks_done;
   int dv[4] = '{timer01_pkg::DIV_SYS12, timer01_pkg::DIV_SYS4,
      timer01_pkg::DIV_SYS48, 2 * timer01_pkg::DIV_EXT8};
   // System clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // External oscillator at half the system rate: one rise every two cycles.
   always @(posedge ref_clk) ext_clk <= rst ? 1'b0 : ~ext_clk;
   cpu_sfr_model cpu_sfr_model_inst (.ref_clk(ref_clk), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata));
   timer01_ctrl timer01_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .vec_timer0(vec_t[0]), .vec_timer1(vec_t[1]),
      .vec_ext_irq0(vec_x[0]), .vec_ext_irq1(vec_x[1]),
      .timer0_count_pin(cnt_pin[0]), .timer1_count_pin(cnt_pin[1]),
      .ext_irq0_input(irq_in[0]), .ext_irq1_input(irq_in[1]),
      .ext_clk(ext_clk), .ext_irq0_polarity(irq_pol[0]),
      .ext_irq1_polarity(irq_pol[1]), .timer0_count_high(t0_high),
      .timer0_high_inc(inc[0]), .timer1_tick(inc[1]),
      .timer1_overflow(t1_ovf),
      .timer2_split(aux_in[0]), .timer3_split(aux_in[1]),
      .timer2_external_select(aux_in[2]),
      .timer3_external_select(aux_in[3]),
      .timer2_low_tick(ticks[0]), .timer2_high_tick(ticks[1]),
      .timer3_low_tick(ticks[2]), .timer3_high_tick(ticks[3]),
      .timer0_overflow_flag(flags[0]), .timer1_overflow_flag(flags[1]),
      .ext_irq0_flag(flags[2]), .ext_irq1_flag(flags[3]));
   // Comparisons; a mismatch is reported at once and counted.
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t register %h not %h", $time, got, exp);
      end
   endtask : check_reg
   task automatic check_pin(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t outputs %b not %b", $time, got, exp);
      end
   endtask : check_pin
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      cpu_sfr_model_inst.read_reg(a, rd);
      check_reg(rd, exp);
   endtask : rd_chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cpu_sfr_model_inst.write_reg(a, d);
   endtask : wr
   // One-cycle pulse on {timer 1 overflow, irq vectors, timer vectors}.
   task automatic pulse(input logic [4:0] v);
      @(posedge ref_clk);
      {t1_ovf, vec_x, vec_t} <= v;
      @(posedge ref_clk);
      {t1_ovf, vec_x, vec_t} <= 5'h00;
      #1;
   endtask : pulse
   // Timer 0 counts n+2 clock edges, or p pin falls in counter mode; it is stopped by the
   // gate, not the run bit, so that its overflow flag survives.
   task automatic run_t0(input logic [7:0] st, input logic [7:0] md,
      input logic [7:0] ck, input int n, input int p);
      wr(timer01_pkg::ADDR_RUN_FLAGS, 8'h00);
      wr(timer01_pkg::ADDR_COUNT_LOW, st);
      wr(timer01_pkg::ADDR_CLK_SEL, ck);
      wr(timer01_pkg::ADDR_MODE, md);
      wr(timer01_pkg::ADDR_RUN_FLAGS, 8'h10);
      for (int k = 0; k < p; k++) begin
         cnt_pin[0] <= 1'b0;
         repeat (3) @(posedge ref_clk);
         cnt_pin[0] <= 1'b1;
         repeat (3) @(posedge ref_clk);
      end
      repeat (n) @(posedge ref_clk);
      #1 fl = flags;
      wr(timer01_pkg::ADDR_MODE, md | 8'h08);
      cpu_sfr_model_inst.read_reg(timer01_pkg::ADDR_COUNT_LOW, rd);
   endtask : run_t0
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   // Guard against a hang.
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      final_report;
   end
   // Main sequence.
   initial begin
      err_count = 0;
      checks_done = 0;
      rst = 1'b1;
      {t1_ovf, vec_t, vec_x, irq_in} = '0;
      cnt_pin = 2'b11;
      irq_pol = 2'b11;
      aux_in = 4'b0011;
      t0_high = 8'hFF;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(timer01_pkg::ADDR_RUN_FLAGS, 8'h00);
      rd_chk(timer01_pkg::ADDR_MODE, 8'h00);
      rd_chk(timer01_pkg::ADDR_COUNT_LOW, 8'h00);
      rd_chk(timer01_pkg::ADDR_CLK_SEL, 8'h00);
      rd_chk(8'h8B, 8'h00);
      wr(timer01_pkg::ADDR_CLK_SEL, 8'hF0);
      rd_chk(timer01_pkg::ADDR_CLK_SEL, 8'hF0);
      check_pin(ticks, 4'hF);
      wr(timer01_pkg::ADDR_MODE, 8'hA5);
      rd_chk(timer01_pkg::ADDR_MODE, 8'hA5);
      run_t0(8'hFD, 8'h01, 8'h04, 5, 0);
      check_reg(rd, 8'h04);
      check_pin(fl, 4'h1);
      rd_chk(timer01_pkg::ADDR_RUN_FLAGS, 8'h30);
      pulse(5'h01);
      rd_chk(timer01_pkg::ADDR_RUN_FLAGS, 8'h10);
      pulse(5'h10);
      check_pin(flags, 4'h2);
      pulse(5'h02);
      check_pin(flags, 4'h0);
      run_t0(8'hFD, 8'h00, 8'h04, 3, 0);
      check_reg(rd, 8'hE2);
      check_pin(fl, 4'h1);
      t0_high <= 8'hA0;
      run_t0(8'hFE, 8'h02, 8'h04, 3, 0);
      check_reg(rd, 8'hA3);
      check_pin(fl, 4'h1);
      run_t0(8'h10, 8'h09, 8'h04, 10, 0);
      check_reg(rd, 8'h10);
      run_t0(8'h00, 8'h05, 8'h04, 2, 3);
      check_reg(rd, 8'h03);
      for (int i = 0; i < 4; i++) begin
         run_t0(8'h00, 8'h01, 8'(i), 46, 0);
         check_reg(rd, 8'(timer01_pkg::DIV_SYS48 / dv[i]));
      end
      // Split timer 0: high byte and timer 1 both on the system clock.
      wr(timer01_pkg::ADDR_CLK_SEL, 8'h0C);
      wr(timer01_pkg::ADDR_MODE, 8'h03);
      wr(timer01_pkg::ADDR_RUN_FLAGS, 8'h40);
      #1 check_pin({2'b00, inc}, 4'h3);
      t0_high <= 8'hFF;
      @(posedge ref_clk);
      #1 check_pin(flags, 4'h2);
      t0_high <= 8'hA0;
      wr(timer01_pkg::ADDR_MODE, 8'h33);
      #1 check_pin({2'b00, inc}, 4'h1);
      // Each external interrupt in level mode, then in edge mode.
      for (int i = 0; i < 2; i++) begin
         wr(timer01_pkg::ADDR_RUN_FLAGS, 8'h00);
         irq_in[i] <= 1'b1;
         repeat (4) @(posedge ref_clk);
         #1 check_pin(flags, 4'(4 << i));
         @(posedge ref_clk);
         irq_in[i] <= 1'b0;
         repeat (4) @(posedge ref_clk);
         #1 check_pin(flags, 4'h0);
         wr(timer01_pkg::ADDR_RUN_FLAGS, 8'h05);
         irq_in[i] <= 1'b1;
         repeat (4) @(posedge ref_clk);
         irq_in[i] <= 1'b0;
         repeat (4) @(posedge ref_clk);
         #1 check_pin(flags, 4'(4 << i));
         pulse(5'(4 << i));
         check_pin(flags, 4'h0);
      end
      final_report;
   end
endmodule : tb_top
`default_nettype wire
